//--- design/pqh_top.sv
// Quiesce handshake for one coherent port, with its register slave.
`timescale 1ns/1ps
`include "pqh_cfg.svh"
// How it works
// [R01] Bit 3 of the capability/status register reads 1 while the port is quiesced, else 0.
// [R02] With the hardware capability strap set, the acknowledge follows the hardware mechanism input.
// [R03] Software may poll the acknowledge instead of waiting only when the capability bit is 1.
// [R04] Without the capability, the acknowledge is set only after the ordered detection steps.
// [R05] Step one is seeing the quiesce request control bit set.
// [R06] Step two is no requests issued and no responses pending for a whole quiesce interval.
// [R07] The interval comes from the programmed time scale and time value fields.
// [R08] After the request rises, the acknowledge is set within twice the interval; the code only flags a miss in interrupt status bit 2.
// [R09] The acknowledge returns to 0 when the quiesced condition is released.
// [R10] Bit 4 reports 1 when a hardware quiescing mechanism exists, else 0.
// [R11] Clearing the request clears the acknowledge and lets requests flow again.
module pqh_top #(
    parameter bit HARDWARE_QUIESCE_ACK_CAP = 1'b0,
    parameter int CW          = 32
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [31:0] regRdData,
    input  wire logic        reqIssued,
    input  wire logic        respPending,
    input  wire logic        hwQuiesced,
    output logic             requestBlock,
    output logic             hwQuiesceReq,
    output logic             irq
);
    import pqh_pkg::*;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    pqh_state_t    state_d;
    pqh_state_t    state_q;
    logic          qreq_d;
    logic          qreq_q;
    logic [2:0]    scale_d;
    logic [2:0]    scale_q;
    logic [7:0]    value_d;
    logic [7:0]    value_q;
    logic [2:0]    irqEn_d;
    logic [2:0]    irqEn_q;
    logic [CW-1:0] quiet_d;
    logic [CW-1:0] quiet_q;
    logic [CW:0]   wait_d;
    logic [CW:0]   wait_q;
    logic          ack_d;
    logic          ack_q;
    logic          block_d;
    logic          block_q;
    logic          hwReq_d;
    logic          hwReq_q;
    logic [31:0]   rd_d;
    logic [31:0]   rd_q;
    logic [CW-1:0] interval;
    logic [2:0]    irqStatus;
    logic [2:0]    irqEvents;
    logic [2:0]    irqClear;
    logic          irqLine;
    logic          timeoutEv;

    // The widest interval, 255 units at the largest scale, needs 27 bits of count.
    if (CW < 27)
    begin : g_cw_check
        $error("pqh_top: CW too small for the longest quiesce interval");
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // ------------------------------------------------------------------------
    // Interval converter and interrupt bank
    // ------------------------------------------------------------------------
    // The interval lags a time register write by one cycle. Software programs
    // the time before raising the request, so the lag never shortens a window.
    pqh_interval #(
        .CW             (CW)
    ) u_interval (
        .clk            (clk),
        .arst_n         (arst_n),
        .timeScale      (scale_q),
        .timeValue      (value_q),
        .intervalCycles (interval)
    );

    pqh_irq #(
        .N          (3)
    ) u_irq (
        .clk        (clk),
        .arst_n     (arst_n),
        .events     (irqEvents),
        .clearBits  (irqClear),
        .enableBits (irqEn_q),
        .status     (irqStatus),
        .irq        (irqLine)
    );

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    always_comb
    begin
        qreq_d   = qreq_q;
        scale_d  = scale_q;
        value_d  = value_q;
        irqEn_d  = irqEn_q;
        irqClear = 3'h0;
        if (regWrite)
        begin
            if (hit(regAddr, `PQH_OFF_CTRL))
            begin
                qreq_d = regWrData[`PQH_CTRL_QREQ_BIT];
            end
            if (hit(regAddr, `PQH_OFF_TIME))
            begin
                value_d = regWrData[`PQH_TIME_VALUE_LSB +: 8]; // [R07]
                scale_d = regWrData[`PQH_TIME_SCALE_LSB +: 3]; // [R07]
            end
            if (hit(regAddr, `PQH_OFF_IRQEN))
            begin
                irqEn_d = regWrData[2:0];
            end
            if (hit(regAddr, `PQH_OFF_IRQCLR))
            begin
                irqClear = regWrData[2:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Quiesce sequence
    // ------------------------------------------------------------------------
    always_comb
    begin
        state_d   = state_q;
        quiet_d   = quiet_q;
        wait_d    = wait_q;
        ack_d     = ack_q;
        timeoutEv = 1'b0;
        // Requests are held back for the whole time the request bit stands.
        block_d   = qreq_q;
        hwReq_d   = qreq_q && HARDWARE_QUIESCE_ACK_CAP;
        unique case (state_q)
            PQH_IDLE:
            begin
                ack_d   = 1'b0; // [R09] [R11]
                quiet_d = '0;
                wait_d  = '0;
                if (qreq_q) // [R05]
                begin
                    state_d = PQH_DRAIN;
                end
            end
            PQH_DRAIN:
            begin
                if (!qreq_q)
                begin
                    state_d = PQH_IDLE; // [R11]
                end
                else if (HARDWARE_QUIESCE_ACK_CAP)
                begin
                    if (hwQuiesced) // [R02]
                    begin
                        state_d = PQH_QUIET;
                        ack_d   = 1'b1;
                    end
                end
                else
                begin
                    // Any activity restarts the continuous quiet count.
                    if (reqIssued || respPending) // [R06]
                    begin
                        quiet_d = '0;
                    end
                    else if (quiet_q + CW'(1) >= interval) // [R04] [R06]
                    begin
                        state_d = PQH_QUIET;
                        ack_d   = 1'b1;
                    end
                    else
                    begin
                        quiet_d = quiet_q + CW'(1);
                    end
                end
                wait_d = wait_q + (CW+1)'(1);
                // The acknowledge must be set inside twice the interval; report a miss.
                if (wait_q == {interval, 1'b0}) // [R08]
                begin
                    timeoutEv = 1'b1;
                end
            end
            PQH_QUIET:
            begin
                // Lost hardware quiescence drops the acknowledge; the request then drains again.
                if (!qreq_q || (HARDWARE_QUIESCE_ACK_CAP && !hwQuiesced))
                begin
                    state_d = PQH_IDLE;
                    ack_d   = 1'b0; // [R09] [R11]
                end
            end
            default:
            begin
                state_d = PQH_IDLE;
                ack_d   = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------------------
    // Bit 0 marks the acknowledge rising, bit 1 its falling, bit 2 a missed deadline.
    // Both edge events compare the registered and next acknowledge, so each fires once.
    assign irqEvents = {timeoutEv, ack_q & ~ack_d, ack_d & ~ack_q};

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    // Data are zero outside the cycle after a read strobe, so a stale word never
    // looks valid to a master that samples one cycle late.
    always_comb
    begin
        rd_d = 32'h0000_0000;
        if (regRead)
        begin
            if (hit(regAddr, `PQH_OFF_CTRL))
            begin
                rd_d[`PQH_CTRL_QREQ_BIT] = qreq_q;
            end
            if (hit(regAddr, `PQH_OFF_CAPSTAT))
            begin
                rd_d[`PQH_CAP_QACK_BIT]  = ack_q;       // [R01] [R03]
                rd_d[`PQH_CAP_HWCAP_BIT] = HARDWARE_QUIESCE_ACK_CAP; // [R10]
            end
            if (hit(regAddr, `PQH_OFF_TIME))
            begin
                rd_d[`PQH_TIME_VALUE_LSB +: 8] = value_q;
                rd_d[`PQH_TIME_SCALE_LSB +: 3] = scale_q;
            end
            if (hit(regAddr, `PQH_OFF_IRQSTAT))
            begin
                rd_d[2:0] = irqStatus;
            end
            if (hit(regAddr, `PQH_OFF_IRQEN))
            begin
                rd_d[2:0] = irqEn_q;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= PQH_IDLE;
            qreq_q  <= 1'b0;
            scale_q <= `PQH_TIME_SCALE_RST;
            value_q <= `PQH_TIME_VALUE_RST;
            irqEn_q <= 3'h0;
            quiet_q <= '0;
            wait_q  <= '0;
            ack_q   <= 1'b0;
            block_q <= 1'b0;
            hwReq_q <= 1'b0;
            rd_q    <= 32'h0000_0000;
        end
        else
        begin
            state_q <= state_d;
            qreq_q  <= qreq_d;
            scale_q <= scale_d;
            value_q <= value_d;
            irqEn_q <= irqEn_d;
            quiet_q <= quiet_d;
            wait_q  <= wait_d;
            ack_q   <= ack_d;
            block_q <= block_d;
            hwReq_q <= hwReq_d;
            rd_q    <= rd_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------

    assign regRdData    = rd_q;
    assign requestBlock = block_q;
    assign hwQuiesceReq = hwReq_q;
    assign irq          = irqLine;
endmodule // pqh_top

//--- design/pqh_cfg.svh
// Constants for the port quiesce handshake: offsets, fields, resets, timing.
`ifndef PQH_CFG_SVH
`define PQH_CFG_SVH
// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define PQH_OFF_CTRL     8'h00
`define PQH_OFF_CAPSTAT  8'h04
`define PQH_OFF_TIME     8'h08
`define PQH_OFF_IRQSTAT  8'h0C
`define PQH_OFF_IRQEN    8'h10
`define PQH_OFF_IRQCLR   8'h14
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PQH_CTRL_QREQ_BIT    0
`define PQH_CAP_QACK_BIT     3
`define PQH_CAP_HWCAP_BIT    4
`define PQH_TIME_VALUE_LSB   0
`define PQH_TIME_SCALE_LSB   8
`define PQH_IRQ_ACK_SET_BIT  0
`define PQH_IRQ_ACK_CLR_BIT  1
`define PQH_IRQ_TIMEOUT_BIT  2
// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define PQH_TIME_VALUE_RST   8'h01
`define PQH_TIME_SCALE_RST   3'h0
`define PQH_CLK_MHZ          25
`define PQH_SCALE_BASE_NS    1000
`define PQH_BASE_CYCLES      ((`PQH_SCALE_BASE_NS * `PQH_CLK_MHZ) / 1000)
`endif

//--- design/pqh_pkg.sv
// Types shared by the port quiesce handshake modules.
package pqh_pkg;
    typedef enum logic [1:0] {
        PQH_IDLE    = 2'b00,
        PQH_DRAIN   = 2'b01,
        PQH_QUIET   = 2'b10
    } pqh_state_t;
endpackage

//--- design/pqh_interval.sv
// Converts time scale and value into a quiesce interval in clock cycles.
`timescale 1ns/1ps
`include "pqh_cfg.svh"
module pqh_interval #(
    parameter int CW = 32
) (
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  wire logic [2:0]    timeScale,
    input  wire logic [7:0]    timeValue,
    output logic      [CW-1:0] intervalCycles
);
    import pqh_pkg::*;
    logic [CW-1:0] interval_d;
    logic [CW-1:0] interval_q;
    // The widest interval, 255 units at the largest scale, needs 27 bits of count.
    if (CW < 27)
    begin : g_cw_check
        $error("pqh_interval: CW too small for the longest quiesce interval");
    end
    // --------------------------------------------------------------------
    // Interval is value times base times 4**scale, never below one cycle.
    // --------------------------------------------------------------------
    always_comb
    begin
        interval_d = CW'(timeValue) * CW'(`PQH_BASE_CYCLES);
        interval_d = interval_d << (2 * timeScale);
        if (interval_d == '0)
        begin
            interval_d = CW'(1);
        end
    end
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            interval_q <= CW'(1);
        end
        else
        begin
            interval_q <= interval_d;
        end
    end
    assign intervalCycles = interval_q;
endmodule // pqh_interval

//--- design/pqh_irq.sv
// Sticky event status, enable and write-one-clear logic with level interrupt.
`timescale 1ns/1ps
module pqh_irq #(
    parameter int N = 3
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [N-1:0] events,
    input  wire logic [N-1:0] clearBits,
    input  wire logic [N-1:0] enableBits,
    output logic      [N-1:0] status,
    output logic              irq
);
    logic [N-1:0] status_d;
    logic [N-1:0] status_q;
    logic         irq_d;
    logic         irq_q;
    if (N < 1)
    begin : g_n_check
        $error("pqh_irq: N must be positive");
    end
    // A set in the same cycle as its clear wins, so no event is lost.
    always_comb
    begin
        status_d = (status_q & ~clearBits) | events;
        irq_d    = |(status_d & enableBits);
    end
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            status_q <= '0;
            irq_q    <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            irq_q    <= irq_d;
        end
    end
    assign status = status_q;
    assign irq    = irq_q;
endmodule // pqh_irq

//--- testbench/pqh_properties.sv
// Concurrent checks on the quiesce handshake top-level ports.
`timescale 1ns/1ps
module pqh_properties #(
    parameter bit HARDWARE_QUIESCE_ACK_CAP = 1'b0
) (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWrData,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regRdData,
    input wire logic        requestBlock,
    input wire logic        hwQuiesceReq,
    input wire logic        irq
);
    logic ctrlWr_d;
    logic ctrlWr_q;
    assign ctrlWr_d = regWrite && regAddr == 8'h00;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ctrlWr_q <= 1'b0;
        else
            ctrlWr_q <= ctrlWr_d;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_rdata_idle: assert property (!$past(regRead) |-> regRdData == 32'h0)
        else $error("read data not zero outside a read cycle");
    a_cap_bit: assert property ($past(regRead) && $past(regAddr) == 8'h04
        |-> regRdData[4] == HARDWARE_QUIESCE_ACK_CAP) else $error("capability bit wrong");
    a_unmapped_zero: assert property ($past(regRead) && $past(regAddr) == 8'h18
        |-> regRdData == 32'h0) else $error("unmapped read not zero");
    a_block_rises: assert property (ctrlWr_d && regWrData[0] |-> ##[1:2] requestBlock)
        else $error("request block did not follow request");
    a_block_falls: assert property (ctrlWr_d && !regWrData[0] |-> ##[1:2] !requestBlock)
        else $error("request block did not release");
    a_block_cause: assert property ($changed(requestBlock)
        |-> ctrlWr_q || $past(ctrlWr_q))
        else $error("request block changed without a control write");
    a_hw_req_cap: assert property (hwQuiesceReq |-> HARDWARE_QUIESCE_ACK_CAP && requestBlock)
        else $error("hardware quiesce request without capability or block");
    a_hw_req_follows: assert property (hwQuiesceReq == (requestBlock && HARDWARE_QUIESCE_ACK_CAP))
        else $error("hardware quiesce request does not follow the block");
    a_irq_off: assert property (regWrite && regAddr == 8'h10 && regWrData[2:0] == 3'h0
        |-> ##2 !irq) else $error("interrupt high with all enables off");
endmodule // pqh_properties

bind pqh_top pqh_properties #(.HARDWARE_QUIESCE_ACK_CAP(HARDWARE_QUIESCE_ACK_CAP)) u_props (
    .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .requestBlock(requestBlock), .hwQuiesceReq(hwQuiesceReq), .irq(irq));

//--- testbench/pqh_port_model.sv
// Port traffic model: issues requests until blocked, each holding a response open.
`timescale 1ns/1ps
module pqh_port_model (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       requestBlock,
    input  wire logic [7:0] respLen,
    output logic            reqIssued,
    output logic            respPending,
    output logic            hwQuiesced
);
    logic [1:0] gap_q;
    logic [7:0] left_q;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            gap_q  <= 2'h0;
            left_q <= 8'h0;
        end
        else
        begin
            gap_q  <= gap_q + 2'h1;
            left_q <= reqIssued ? respLen : (left_q != 8'h0 ? left_q - 8'h1 : 8'h0);
        end
    end
    // Requests stop while blocked; a long respLen keeps the port busy long enough that the acknowledge misses the timeout.
    assign reqIssued   = arst_n && !requestBlock && gap_q == 2'h3;
    assign respPending = left_q != 8'h0;
    assign hwQuiesced  = requestBlock && !respPending;
endmodule // pqh_port_model

//--- testbench/tb_top.sv
// Self-checking bench for the port quiesce handshake.
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [7:0]  respLen = 8'h03;
    logic [31:0] regRdData;
    logic        reqIssued, respPending, hwQuiesced, requestBlock, hwQuiesceReq, irq;
    logic        selHw = 1'b0;
    logic [31:0] regRdDataHw;
    logic        reqIssuedHw, respPendingHw, hwQuiescedHw, requestBlockHw, hwQuiesceReqHw;
    int          nMismatch = 0;
    int          numChecks = 0;
    always #20 clk = ~clk;
    pqh_top dut (.clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite && !selHw), .regRead(regRead && !selHw), .regRdData(regRdData),
        .reqIssued(reqIssued),
        .respPending(respPending), .hwQuiesced(hwQuiesced), .requestBlock(requestBlock),
        .hwQuiesceReq(hwQuiesceReq), .irq(irq));
    pqh_port_model u_port (.clk(clk), .arst_n(arst_n), .requestBlock(requestBlock),
        .respLen(respLen), .reqIssued(reqIssued), .respPending(respPending),
        .hwQuiesced(hwQuiesced));
    // A second copy with the hardware mechanism sees the bus strobes only while selHw is high.
    pqh_top #(.HARDWARE_QUIESCE_ACK_CAP(1'b1)) dutHw (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite && selHw), .regRead(regRead && selHw),
        .regRdData(regRdDataHw), .reqIssued(reqIssuedHw), .respPending(respPendingHw),
        .hwQuiesced(hwQuiescedHw), .requestBlock(requestBlockHw),
        .hwQuiesceReq(hwQuiesceReqHw), .irq());
    pqh_port_model uHwPort (.clk(clk), .arst_n(arst_n), .requestBlock(requestBlockHw),
        .respLen(respLen), .reqIssued(reqIssuedHw), .respPending(respPendingHw),
        .hwQuiesced(hwQuiescedHw));
    task automatic printVerdict;
        if (nMismatch == 0 && numChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk($sformatf("register %h", a), exp, selHw ? regRdDataHw : regRdData);
    endtask
    task automatic waitCycles(input int n);
        repeat (n) @(posedge clk);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial
    begin
        waitCycles(2);
        arst_n <= 1'b1;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h1);
        rd(8'h18, 32'h0);
        wr(8'h04, 32'hFFFFFFFF);
        rd(8'h04, 32'h0);
        wr(8'h08, 32'h2);
        rd(8'h08, 32'h2);
        wr(8'h10, 32'h7);
        // Software waits the full time here, since the capability bit reads 0.
        wr(8'h00, 32'h1);
        waitCycles(40);
        rd(8'h04, 32'h0);
        chk("requestBlock", 32'h1, {31'h0, requestBlock});
        waitCycles(50);
        rd(8'h04, 32'h8);
        rd(8'h0C, 32'h1);
        chk("irq", 32'h1, {31'h0, irq});
        wr(8'h00, 32'h0);
        waitCycles(3);
        rd(8'h04, 32'h0);
        rd(8'h0C, 32'h3);
        chk("requestBlock", 32'h0, {31'h0, requestBlock});
        wr(8'h14, 32'h7);
        rd(8'h0C, 32'h0);
        waitCycles(2);
        #1 chk("irq", 32'h0, {31'h0, irq});
        // Slow responses delay the acknowledge beyond twice the interval.
        wr(8'h08, 32'h1);
        respLen <= 8'h28;
        waitCycles(4);
        wr(8'h00, 32'h1);
        waitCycles(55);
        rd(8'h04, 32'h0);
        rd(8'h0C, 32'h4);
        waitCycles(40);
        rd(8'h04, 32'h8);
        wr(8'h10, 32'h0);
        waitCycles(3);
        #1 chk("irq", 32'h0, {31'h0, irq});
        // The copy with the hardware mechanism may be polled instead of waited on.
        selHw <= 1'b1;
        respLen <= 8'h03;
        rd(8'h04, 32'h10);
        wr(8'h00, 32'h1);
        waitCycles(8);
        rd(8'h04, 32'h18);
        chk("hwQuiesceReq", 32'h1, {31'h0, hwQuiesceReqHw});
        wr(8'h00, 32'h0);
        rd(8'h04, 32'h10);
        chk("hwQuiesceReq", 32'h0, {31'h0, hwQuiesceReqHw});
        printVerdict();
    end
    initial
    begin
        waitCycles(2000);
        nMismatch++;
        printVerdict();
    end
endmodule // tb_top
